// [rtl/dbvid_i2c_slave.v]
// What this block does
// - Same protocol at 100 and 400 kbps
// - Only 7-bit addresses, no general call
// - Fixed upper address bits, strap sets two
// - Strap grounded answers at 0x60
// - Open/high map to 0x61/0x62, selectable
// - Acknowledge low through ninth clock high
// - Register updates at data LSB falling edge
// - Hardware shutdown of both converters blocks register updates
// - Software shutdown keeps interface fully working
// - Registers kept until supply-fail reset
// - Five 8-bit registers at 0x00 to 0x04
// - Seven-bit voltage code, 10 mV steps
// - Go bit selects register voltage code
// - Light-load mode field, output off bit
// - Slew field: one step per 2^n cycles
// - Status: temperature, two power-good bits
// Serial slave with register bank; bus pins come from outside mclk domain
// Assumes reset is driven by the supply monitor below the retention threshold
`timescale 1ns/10ps
`include "dbvid_map.vh"
module dbvid_i2c_slave (
    // Clock and reset
    input wire mclk,
    input wire reset,
    // Serial bus
    input wire sclIn,
    input wire sdaIn,
    output reg sdaOut,
    output reg sdaOe,
    // Address strap and its mapping choice
    input wire [1:0] addrStrap,
    input wire strapSwap,
    // Hardware enable pins
    input wire converter1_hw_enable_pin,
    input wire converter2_hw_enable_pin,
    // Status inputs
    input wire output1_in_regulation,
    input wire output2_in_regulation,
    input wire dieTempWarn,
    // Converter 1 controls
    output reg output1_go_bit,
    output reg [6:0] out1VoltCode,
    output reg [2:0] out1Slew,
    output reg [1:0] out1LightLoad,
    output reg output1_off,
    // Converter 2 controls
    output reg output2_go_bit,
    output reg [6:0] out2VoltCode,
    output reg [2:0] out2Slew,
    output reg [1:0] out2LightLoad,
    output reg output2_off
);
    localparam ST_IDLE = 3'h0;
    localparam ST_ADDR = 3'h1;
    localparam ST_PTR = 3'h2;
    localparam ST_DATA = 3'h3;
    localparam ST_READ = 3'h4;
    localparam ST_ACK = 3'h5;
    localparam ST_RACK = 3'h6;
    localparam [15:0] SETTLE_CYC = `DBVID_STRAP_SETTLE_CYC;

    // Address selected by a strap code
    function [6:0] strapAddr;
        input [1:0] strap;
        input swap;
        begin
            case (strap)
                `DBVID_STRAP_LOW: strapAddr = `DBVID_ADDR_GROUND;
                `DBVID_STRAP_OPEN: strapAddr = swap ? `DBVID_ADDR_ALT_B : `DBVID_ADDR_ALT_A;
                default: strapAddr = swap ? `DBVID_ADDR_ALT_A : `DBVID_ADDR_ALT_B;
            endcase
        end
    endfunction

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    reg [1:0] sclSync_reg;
    reg [1:0] sdaSync_reg;
    reg [1:0] en1Sync_reg;
    reg [1:0] en2Sync_reg;
    reg [1:0] strapS0_reg;
    reg [1:0] strapS1_reg;
    reg swapS0_reg;
    reg swapS1_reg;
    reg sclPrev_reg;
    reg sdaPrev_reg;
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            sclSync_reg <= 2'h3;
            sdaSync_reg <= 2'h3;
            en1Sync_reg <= 2'h0;
            en2Sync_reg <= 2'h0;
            strapS0_reg <= 2'h0;
            strapS1_reg <= 2'h0;
            swapS0_reg <= 1'b0;
            swapS1_reg <= 1'b0;
            sclPrev_reg <= 1'b1;
            sdaPrev_reg <= 1'b1;
        end else begin
            sclSync_reg <= {sclSync_reg[0], sclIn};
            sdaSync_reg <= {sdaSync_reg[0], sdaIn};
            en1Sync_reg <= {en1Sync_reg[0], converter1_hw_enable_pin};
            en2Sync_reg <= {en2Sync_reg[0], converter2_hw_enable_pin};
            strapS0_reg <= addrStrap;
            strapS1_reg <= strapS0_reg;
            swapS0_reg <= strapSwap;
            swapS1_reg <= swapS0_reg;
            sclPrev_reg <= sclSync_reg[1];
            sdaPrev_reg <= sdaSync_reg[1];
        end
    end
    wire scl = sclSync_reg[1];
    wire sda = sdaSync_reg[1];
    wire sclRise = scl & ~sclPrev_reg;
    wire sclFall = ~scl & sclPrev_reg;
    wire startCond = scl & sclPrev_reg & sdaPrev_reg & ~sda;
    wire stopCond = scl & sclPrev_reg & ~sdaPrev_reg & sda;
    wire hwShutdown = ~en1Sync_reg[1] & ~en2Sync_reg[1];

    // ----------------------------------------
    // Strap capture after reset release
    // ----------------------------------------
    reg [15:0] settle_reg;
    reg [6:0] myAddr_reg;
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            settle_reg <= 16'h0000;
            myAddr_reg <= `DBVID_ADDR_GROUND;
        end else if (settle_reg != SETTLE_CYC) begin
            settle_reg <= settle_reg + 16'h0001;
            myAddr_reg <= strapAddr(strapS1_reg, swapS1_reg);
        end
    end

    // ----------------------------------------
    // Serial state machine
    // ----------------------------------------
    reg [2:0] state_reg;
    reg [2:0] retState_reg;
    reg [3:0] bitCnt_reg;
    reg [7:0] shift_reg;
    reg [7:0] ptr_reg;
    reg ackDrive_reg;
    reg masterNak_reg;
    reg memWr_reg;
    reg [7:0] status_reg;
    wire [7:0] memRd;
    wire [7:0] w0;
    wire [7:0] w1;
    wire [7:0] w2;
    wire [7:0] w3;
    wire byteDone = sclFall & (bitCnt_reg == 4'h7);
    wire [7:0] rxByte = {shift_reg[6:0], sda};
    reg [7:0] rxLatch_reg;
    wire ptrValid = (ptr_reg < `DBVID_NUM_REGS);
    wire [7:0] rdByte = (ptr_reg == `DBVID_PTR_SYS_COND) ? status_reg : (ptrValid ? memRd : 8'h00);

    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            state_reg <= ST_IDLE;
            retState_reg <= ST_IDLE;
            bitCnt_reg <= 4'h0;
            shift_reg <= 8'h00;
            rxLatch_reg <= 8'h00;
            ptr_reg <= 8'h00;
            ackDrive_reg <= 1'b0;
            masterNak_reg <= 1'b0;
            memWr_reg <= 1'b0;
            sdaOut <= 1'b1;
            sdaOe <= 1'b0;
        end else begin
            memWr_reg <= 1'b0;
            if (sclRise && state_reg != ST_READ)
                shift_reg <= rxByte;
            if (startCond) begin
                state_reg <= ST_ADDR;
                // Clock fall that ends the start is not a data bit
                bitCnt_reg <= 4'hF;
                sdaOe <= 1'b0;
            end else if (stopCond) begin
                state_reg <= ST_IDLE;
                sdaOe <= 1'b0;
            end else begin
                case (state_reg)
                    ST_ADDR, ST_PTR, ST_DATA: begin
                        if (sclRise && bitCnt_reg == 4'h7)
                            rxLatch_reg <= rxByte;
                        if (sclFall)
                            bitCnt_reg <= bitCnt_reg + 4'h1;
                        if (byteDone) begin
                            bitCnt_reg <= 4'h0;
                            if (state_reg == ST_ADDR) begin
                                if (rxLatch_reg[7:1] == myAddr_reg) begin
                                    sdaOe <= 1'b1;
                                    sdaOut <= 1'b0;
                                    state_reg <= ST_ACK;
                                    retState_reg <= rxLatch_reg[0] ? ST_READ : ST_PTR;
                                end else begin
                                    state_reg <= ST_IDLE;
                                end
                            end else if (state_reg == ST_PTR) begin
                                ptr_reg <= rxLatch_reg;
                                sdaOe <= 1'b1;
                                sdaOut <= 1'b0;
                                state_reg <= ST_ACK;
                                retState_reg <= ST_DATA;
                            end else begin
                                if (!hwShutdown && ptrValid && ptr_reg != `DBVID_PTR_SYS_COND)
                                    memWr_reg <= 1'b1;
                                ptr_reg <= ptr_reg + 8'h01;
                                sdaOe <= 1'b1;
                                sdaOut <= 1'b0;
                                state_reg <= ST_ACK;
                                retState_reg <= ST_DATA;
                            end
                        end
                    end
                    ST_ACK: begin
                        if (sclFall) begin
                            state_reg <= retState_reg;
                            bitCnt_reg <= 4'h0;
                            if (retState_reg == ST_READ) begin
                                shift_reg <= rdByte;
                                sdaOe <= ~rdByte[7];
                                sdaOut <= 1'b0;
                            end else begin
                                sdaOe <= 1'b0;
                            end
                        end
                    end
                    ST_READ: begin
                        if (sclFall) begin
                            if (bitCnt_reg == 4'h7) begin
                                sdaOe <= 1'b0;
                                state_reg <= ST_RACK;
                                ptr_reg <= ptr_reg + 8'h01;
                            end else begin
                                bitCnt_reg <= bitCnt_reg + 4'h1;
                                sdaOe <= ~shift_reg[6 - bitCnt_reg[2:0]];
                                sdaOut <= 1'b0;
                            end
                        end
                    end
                    ST_RACK: begin
                        if (sclRise)
                            masterNak_reg <= sda;
                        if (sclFall) begin
                            bitCnt_reg <= 4'h0;
                            if (masterNak_reg) begin
                                state_reg <= ST_IDLE;
                            end else begin
                                state_reg <= ST_READ;
                                shift_reg <= rdByte;
                                sdaOe <= ~rdByte[7];
                                sdaOut <= 1'b0;
                            end
                        end
                    end
                    default: state_reg <= ST_IDLE;
                endcase
            end
        end
    end

    // ----------------------------------------
    // Register bank and status
    // ----------------------------------------
    reg [7:0] memWrData_reg;
    reg [1:0] memWrAddr_reg;
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            memWrData_reg <= 8'h00;
            memWrAddr_reg <= 2'h0;
            status_reg <= 8'h00;
        end else begin
            if (byteDone && state_reg == ST_DATA) begin
                memWrData_reg <= rxLatch_reg;
                memWrAddr_reg <= ptr_reg[1:0];
            end
            status_reg <= {5'h00, dieTempWarn, output2_in_regulation, output1_in_regulation};
        end
    end

    dbvid_reg_mem uMem (
        .mclk(mclk),
        .reset(reset),
        .wrEn(memWr_reg),
        .wrAddr(memWrAddr_reg),
        .wrData(memWrData_reg),
        .rdAddr(ptr_reg[1:0]),
        .rdData(memRd),
        .word0(w0),
        .word1(w1),
        .word2(w2),
        .word3(w3)
    );

    // ----------------------------------------
    // Converter control outputs
    // ----------------------------------------
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            output1_go_bit <= 1'b0;
            out1VoltCode <= 7'h00;
            out1Slew <= 3'h0;
            out1LightLoad <= 2'h0;
            output1_off <= 1'b0;
            output2_go_bit <= 1'b0;
            out2VoltCode <= 7'h00;
            out2Slew <= 3'h0;
            out2LightLoad <= 2'h0;
            output2_off <= 1'b0;
        end else begin
            output1_go_bit <= w0[`DBVID_VSEL_GO_BIT];
            out1VoltCode <= w0[`DBVID_VSEL_CODE_MSB:0];
            output2_go_bit <= w1[`DBVID_VSEL_GO_BIT];
            out2VoltCode <= w1[`DBVID_VSEL_CODE_MSB:0];
            out1Slew <= w2[`DBVID_CMD_SLEW_MSB:`DBVID_CMD_SLEW_LSB];
            out1LightLoad <= w2[`DBVID_CMD_LL_MSB:`DBVID_CMD_LL_LSB];
            output1_off <= w2[`DBVID_CMD_OFF_BIT];
            out2Slew <= w3[`DBVID_CMD_SLEW_MSB:`DBVID_CMD_SLEW_LSB];
            out2LightLoad <= w3[`DBVID_CMD_LL_MSB:`DBVID_CMD_LL_LSB];
            output2_off <= w3[`DBVID_CMD_OFF_BIT];
        end
    end
endmodule

// [rtl/dbvid_map.vh]
// Register map, field positions, reset values and timing counts of the regulator serial slave
// Assumes inclusion by the slave design files and the bench
`ifndef DBVID_MAP_VH
`define DBVID_MAP_VH
// ----------------------------------------
// Register pointers
// ----------------------------------------
`define DBVID_PTR_OUT1_VSEL 8'h00
`define DBVID_PTR_OUT2_VSEL 8'h01
`define DBVID_PTR_OUT1_CMD 8'h02
`define DBVID_PTR_OUT2_CMD 8'h03
`define DBVID_PTR_SYS_COND 8'h04
`define DBVID_NUM_REGS 5
// ----------------------------------------
// Field positions
// ----------------------------------------
`define DBVID_VSEL_GO_BIT 7
`define DBVID_VSEL_CODE_MSB 6
`define DBVID_CMD_SLEW_MSB 6
`define DBVID_CMD_SLEW_LSB 4
`define DBVID_CMD_LL_MSB 2
`define DBVID_CMD_LL_LSB 1
`define DBVID_CMD_OFF_BIT 0
`define DBVID_CMD_WRITE_MASK 8'h77
`define DBVID_STAT_TEMP_BIT 2
`define DBVID_STAT_PG2_BIT 1
`define DBVID_STAT_PG1_BIT 0
// ----------------------------------------
// Reset values
// ----------------------------------------
`define DBVID_RESET_VSEL 8'h00
`define DBVID_RESET_CMD 8'h00
// ----------------------------------------
// Slave addresses
// ----------------------------------------
`define DBVID_ADDR_GROUND 7'h60
`define DBVID_ADDR_ALT_A 7'h61
`define DBVID_ADDR_ALT_B 7'h62
// ----------------------------------------
// Strap states
// ----------------------------------------
`define DBVID_STRAP_LOW 2'h0
`define DBVID_STRAP_OPEN 2'h1
`define DBVID_STRAP_HIGH 2'h2
// ----------------------------------------
// Timing
// ----------------------------------------
`define DBVID_CLK_MHZ 100
`define DBVID_STRAP_SETTLE_NS 1000
`define DBVID_STRAP_SETTLE_CYC ((`DBVID_STRAP_SETTLE_NS * `DBVID_CLK_MHZ) / 1000)
`endif

// [rtl/dbvid_reg_mem.v]
// Four-word register memory for the two voltage-select and two command registers
// Assumes one write port and one registered read port on the system clock
`timescale 1ns/10ps
`include "dbvid_map.vh"
module dbvid_reg_mem (
    // Clock and reset
    input wire mclk,
    input wire reset,
    // Write port
    input wire wrEn,
    input wire [1:0] wrAddr,
    input wire [7:0] wrData,
    // Read port
    input wire [1:0] rdAddr,
    output reg [7:0] rdData,
    // Whole-word views for the converters
    output wire [7:0] word0,
    output wire [7:0] word1,
    output wire [7:0] word2,
    output wire [7:0] word3
);
    reg [7:0] mem0;
    reg [7:0] mem1;
    reg [7:0] mem2;
    reg [7:0] mem3;
    assign word0 = mem0;
    assign word1 = mem1;
    assign word2 = mem2;
    assign word3 = mem3;
    // ----------------------------------------
    // Storage, kept until reset from supply monitor
    // ----------------------------------------
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            mem0 <= `DBVID_RESET_VSEL;
            mem1 <= `DBVID_RESET_VSEL;
            mem2 <= `DBVID_RESET_CMD;
            mem3 <= `DBVID_RESET_CMD;
            rdData <= 8'h00;
        end else begin
            if (wrEn) begin
                case (wrAddr)
                    2'h0: mem0 <= wrData;
                    2'h1: mem1 <= wrData;
                    2'h2: mem2 <= wrData & `DBVID_CMD_WRITE_MASK;
                    default: mem3 <= wrData & `DBVID_CMD_WRITE_MASK;
                endcase
            end
            case (rdAddr)
                2'h0: rdData <= mem0;
                2'h1: rdData <= mem1;
                2'h2: rdData <= mem2;
                default: rdData <= mem3;
            endcase
        end
    end
endmodule

// [tb/dbvid_master_model.sv]
// Bus master model for the regulator serial slave
// Assumes the bench resolves the data line with a pull-up
`timescale 1ns/10ps
module dbvid_master_model (
    // Clock
    input logic mclk,
    // Bus
    input logic sdaLine,
    output logic scl,
    output logic sdaLow
);
    // ----------------------------------------
    // Bit, start and stop timing, 80 ns bit
    // ----------------------------------------
    initial begin
        scl = 1'h1;
        sdaLow = 1'h0;
    end
    task automatic w(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic sbit(input logic b, output logic s);
        w(1);
        sdaLow <= ~b;
        w(3);
        scl <= 1'h1;
        w(2);
        s = sdaLine;
        w(2);
        scl <= 1'h0;
    endtask
    task automatic startc;
        w(1);
        sdaLow <= 1'h0;
        w(3);
        scl <= 1'h1;
        w(4);
        sdaLow <= 1'h1;
        w(4);
        scl <= 1'h0;
    endtask
    task automatic stopc;
        w(1);
        sdaLow <= 1'h1;
        w(3);
        scl <= 1'h1;
        w(4);
        sdaLow <= 1'h0;
        w(4);
    endtask
    task automatic xb(input logic [7:0] d, input logic last, output logic [7:0] q, output logic nine);
        for (int i = 7; i >= 0; i--) begin
            sbit(d[i], q[i]);
        end
        sbit(last, nine);
    endtask
endmodule

// [tb/dbvid_i2c_slave_asserts.sv]
// Port checker of the regulator serial slave
// Assumes binding to dbvid_i2c_slave
`timescale 1ns/10ps
module dbvid_i2c_slave_asserts (
    // Clock and reset
    input logic mclk,
    input logic reset,
    // Bus
    input logic sclIn,
    input logic sdaOut,
    input logic sdaOe,
    // Enables
    input logic converter1_hw_enable_pin,
    input logic converter2_hw_enable_pin,
    // Controls
    input logic output1_go_bit,
    input logic [6:0] out1VoltCode,
    input logic [2:0] out1Slew,
    input logic [1:0] out1LightLoad,
    input logic output1_off,
    input logic output2_go_bit,
    input logic [6:0] out2VoltCode,
    input logic [2:0] out2Slew,
    input logic [1:0] out2LightLoad,
    input logic output2_off
);
    // ----------------------------------------
    // Helper counters
    // ----------------------------------------
    logic sclPrev;
    logic [3:0] sinceFall;
    logic [3:0] sclHigh;
    logic [3:0] shutCnt;
    wire [13:0] ctl1 = {output1_go_bit, out1VoltCode, out1Slew, out1LightLoad, output1_off};
    wire [13:0] ctl2 = {output2_go_bit, out2VoltCode, out2Slew, out2LightLoad, output2_off};
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            sclPrev <= 1'h1;
            sinceFall <= 4'hF;
            sclHigh <= 4'h0;
            shutCnt <= 4'h0;
        end else begin
            sclPrev <= sclIn;
            sinceFall <= (sclPrev && !sclIn) ? 4'h0 : sinceFall + {3'h0, sinceFall != 4'hF};
            sclHigh <= !sclIn ? 4'h0 : sclHigh + {3'h0, sclHigh != 4'hF};
            shutCnt <= (converter1_hw_enable_pin || converter2_hw_enable_pin) ? 4'h0 :
                shutCnt + {3'h0, shutCnt != 4'hF};
        end
    end
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    sequence ackStart;
        $rose(sdaOe);
    endsequence
    sequence ackHold;
        sdaOe [*6];
    endsequence
    a_drive_low_only: assert property (sdaOe |-> !sdaOut)
        else $error("data line driven high");
    a_ack_holds: assert property (ackStart |=> ackHold)
        else $error("data pull released early");
    a_idle_released: assert property (sclHigh >= 4'h7 |-> !sdaOe)
        else $error("data pulled while clock idles");
    a_reset_quiet: assert property ($fell(reset) |-> !sdaOe [*8])
        else $error("data pulled after reset");
    a_upd1_window: assert property ($changed(ctl1) |-> sinceFall >= 4'h2 && sinceFall <= 4'h7)
        else $error("converter 1 update off clock fall");
    a_upd2_window: assert property ($changed(ctl2) |-> sinceFall >= 4'h2 && sinceFall <= 4'h7)
        else $error("converter 2 update off clock fall");
    a_hw_hold1: assert property (shutCnt >= 4'h4 |-> $stable(ctl1))
        else $error("converter 1 changed in shutdown");
    a_hw_hold2: assert property (shutCnt >= 4'h4 |-> $stable(ctl2))
        else $error("converter 2 changed in shutdown");
endmodule
bind dbvid_i2c_slave dbvid_i2c_slave_asserts chkU (.mclk(mclk), .reset(reset), .sclIn(sclIn),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .converter1_hw_enable_pin(converter1_hw_enable_pin),
    .converter2_hw_enable_pin(converter2_hw_enable_pin), .output1_go_bit(output1_go_bit),
    .out1VoltCode(out1VoltCode), .out1Slew(out1Slew), .out1LightLoad(out1LightLoad),
    .output1_off(output1_off), .output2_go_bit(output2_go_bit), .out2VoltCode(out2VoltCode),
    .out2Slew(out2Slew), .out2LightLoad(out2LightLoad), .output2_off(output2_off));

// [tb/tb.sv]
// Self-checking bench of the regulator serial slave
// Assumes the master model and the bound port checker
`timescale 1ns/10ps
`include "dbvid_map.vh"
module tb;
    // ----------------------------------------
    // Wiring
    // ----------------------------------------
    logic mclk = 1'h0;
    logic reset = 1'h1;
    logic sclLine, sdaLow, sdaOut, sdaOe, strapSwap = 1'h0;
    logic [1:0] addrStrap = 2'h0;
    logic en1 = 1'h1, en2 = 1'h1, pg1 = 1'h0, pg2 = 1'h0, tempW = 1'h0;
    logic go1, off1, go2, off2;
    logic [6:0] code1, code2;
    logic [2:0] slew1, slew2;
    logic [1:0] ll1, ll2;
    logic [7:0] sh [0:3];
    logic [31:0] seed = 32'h4F76C3A9;
    int miscompares = 0;
    int checksDone = 0;
    logic [17:0] corner [0:5] = '{18'h302FF, 18'h30301, 18'h300A5, 18'h0015A, 18'h304FF, 18'h30533};
    wire sdaBus = ~(sdaLow | (sdaOe & ~sdaOut));
    always #5 mclk = ~mclk;
    dbvid_master_model masterU (.mclk(mclk), .sdaLine(sdaBus), .scl(sclLine), .sdaLow(sdaLow));
    dbvid_i2c_slave dut_u (.mclk(mclk), .reset(reset), .sclIn(sclLine), .sdaIn(sdaBus), .sdaOut(sdaOut),
        .sdaOe(sdaOe), .addrStrap(addrStrap), .strapSwap(strapSwap), .converter1_hw_enable_pin(en1),
        .converter2_hw_enable_pin(en2), .output1_in_regulation(pg1), .output2_in_regulation(pg2),
        .dieTempWarn(tempW), .output1_go_bit(go1), .out1VoltCode(code1), .out1Slew(slew1),
        .out1LightLoad(ll1), .output1_off(off1), .output2_go_bit(go2), .out2VoltCode(code2),
        .out2Slew(slew2), .out2LightLoad(ll2), .output2_off(off2));
    // ----------------------------------------
    // Expectations and transfers
    // ----------------------------------------
    function automatic logic [31:0] nx(input logic [31:0] v);
        logic [31:0] t;
        t = v ^ (v << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    function automatic [6:0] expAddr(input [1:0] s, input logic w);
        if (s == `DBVID_STRAP_LOW) return `DBVID_ADDR_GROUND;
        return ((s == `DBVID_STRAP_OPEN) ^ w) ? `DBVID_ADDR_ALT_A : `DBVID_ADDR_ALT_B;
    endfunction
    function automatic [7:0] expRd(input [7:0] p);
        if (p < 8'h04) return sh[p[1:0]];
        if (p == 8'h04) return {5'h00, tempW, pg2, pg1};
        return 8'h00;
    endfunction
    task automatic chk(input logic [7:0] g, input logic [7:0] e, input string m);
        checksDone++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected at %0t ns: %s got %h expected %h", $time, m, g, e);
        end
    endtask
    task automatic chkPorts;
        chk({go1, code1}, sh[0], "output 1 voltage");
        chk({go2, code2}, sh[1], "output 2 voltage");
        chk({1'h0, slew1, 1'h0, ll1, off1}, sh[2], "output 1 command");
        chk({1'h0, slew2, 1'h0, ll2, off2}, sh[3], "output 2 command");
    endtask
    task automatic wr(input [6:0] a, input [7:0] p, input [7:0] d, input logic ackExp);
        logic [7:0] q;
        logic n;
        masterU.startc();
        masterU.xb({a, 1'h0}, 1'h1, q, n);
        chk({7'h00, n}, {7'h00, !ackExp}, "address ack");
        if (ackExp) begin
            masterU.xb(p, 1'h1, q, n);
            chk({7'h00, n}, 8'h00, "pointer ack");
            masterU.xb(d, 1'h1, q, n);
            chk({7'h00, n}, 8'h00, "data ack");
            chkPorts();
        end
        masterU.stopc();
    endtask
    task automatic rd(input [6:0] a, input [7:0] p, output [7:0] q);
        logic n;
        masterU.startc();
        masterU.xb({a, 1'h0}, 1'h1, q, n);
        masterU.xb(p, 1'h1, q, n);
        masterU.startc();
        masterU.xb({a, 1'h1}, 1'h1, q, n);
        chk({7'h00, n}, 8'h00, "read address ack");
        masterU.xb(8'hFF, 1'h1, q, n);
        masterU.stopc();
    endtask
    task automatic doReset(input [1:0] s, input logic w);
        reset <= 1'h1;
        addrStrap <= s;
        strapSwap <= w;
        repeat (6) @(posedge mclk);
        reset <= 1'h0;
        repeat (110) @(posedge mclk);
        for (int i = 0; i < 4; i++) begin
            sh[i] = 8'h00;
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d, mismatches %0d", checksDone, miscompares);
        if (miscompares == 0 && checksDone > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // ----------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------
    initial begin
        logic [7:0] q, p, d;
        logic [6:0] a;
        logic [1:0] e;
        for (int s = 0; s < 3; s++) begin
            for (int w = 0; w < 2; w++) begin
                doReset(s[1:0], w[0]);
                a = expAddr(s[1:0], w[0]);
                for (int i = 0; i < 4; i++) begin
                    rd(a, i[7:0], q);
                    chk(q, 8'h00, "reset value");
                end
                seed = nx(seed);
                sh[0] = seed[7:0];
                wr(a, 8'h00, seed[7:0], 1'h1);
                wr((a == `DBVID_ADDR_ALT_B) ? `DBVID_ADDR_GROUND : a + 7'h01, 8'h00, 8'h00, 1'h0);
                wr(7'h00, 8'h00, 8'h00, 1'h0);
                wr(7'h78, 8'h00, 8'h00, 1'h0);
                rd(a, 8'h00, q);
                chk(q, sh[0], "readback");
            end
        end
        for (int i = 0; i < 24; i++) begin
            seed = nx(seed);
            {e, p, d} = (i < 6) ? corner[i] : {seed[17:16], 8'(seed[15:8] % 6), seed[7:0]};
            en1 <= e[1];
            en2 <= e[0];
            pg1 <= seed[20];
            pg2 <= seed[21];
            tempW <= seed[22];
            repeat (4) @(posedge mclk);
            if (e != 2'h0 && p < 8'h04) sh[p[1:0]] = p[1] ? (d & `DBVID_CMD_WRITE_MASK) : d;
            wr(a, p, d, 1'h1);
            rd(a, p, q);
            chk(q, expRd(p), "register read");
        end
        give_verdict();
    end
    initial begin
        repeat (90000) @(posedge mclk);
        miscompares++;
        $display("unexpected at %0t ns: run did not finish", $time);
        give_verdict();
    end
endmodule
